// ===== logic/sca_timer.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "sca_defines.svh"

module sca_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire sca_pkg::sca_apb_req_t apb,
   input wire logic slow_clock,
   output logic [`SCA_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   import sca_pkg::*;

   sca_state_t st;
   sca_state_t next_st;
   logic slow_rise;
   logic setup;
   logic access;
   logic mapped;
   logic div_wrap;
   logic alarm_hit;
   logic [`SCA_PW:0] period;

   always_comb
   begin
      next_st = st;
      slow_rise = slow_clock && !st.sclk_q;
      next_st.sclk_q = slow_clock;
      setup = apb.psel && !apb.penable;
      access = apb.psel && apb.penable;
      mapped = 1'b0;
      if (apb.paddr == `SCA_OFF_MODE)
      begin
         mapped = 1'b1;
      end
      else if (apb.paddr == `SCA_OFF_ALARM)
      begin
         mapped = 1'b1;
      end
      else if (apb.paddr == `SCA_OFF_COUNT)
      begin
         mapped = 1'b1;
      end
      else if (apb.paddr == `SCA_OFF_FLAGS)
      begin
         mapped = 1'b1;
      end
      // A zero field selects the longest period.
      period = (st.prescale == '0) ? `SCA_PERIOD_MAX : {1'b0, st.prescale};
      div_wrap = slow_rise && (({1'b0, st.div} + 17'h00001) == period);
      // Widened compare keeps an all-ones alarm from ever matching.
      alarm_hit = ({1'b0, st.count} == ({1'b0, st.alarm} + 33'h000000001));

      if (slow_rise)
      begin
         if (div_wrap)
         begin
            next_st.div = '0;
            next_st.count = st.count + 32'h00000001;
         end
         else
         begin
            next_st.div = st.div + 16'h0001;
         end
      end

      // Restart and flag clear wait for two slow clock edges.
      if (slow_rise && st.rst_cnt != 2'h0)
      begin
         next_st.rst_cnt = st.rst_cnt - 2'h1;
         if (st.rst_cnt == 2'h1)
         begin
            next_st.div = '0;
            next_st.count = `SCA_RST_COUNT;
         end
      end
      if (slow_rise && st.clr_cnt != 2'h0)
      begin
         next_st.clr_cnt = st.clr_cnt - 2'h1;
         if (st.clr_cnt == 2'h1)
         begin
            next_st.alarm_flag = 1'b0;
            next_st.tick_flag = 1'b0;
         end
      end

      // Setting comes after clearing so a coincident event is kept.
      if (div_wrap)
      begin
         next_st.tick_flag = 1'b1;
      end
      if (alarm_hit)
      begin
         next_st.alarm_flag = 1'b1;
      end

      // Read data is captured in the setup cycle and held for the access.
      if (setup && !apb.pwrite)
      begin
         if (apb.paddr == `SCA_OFF_MODE)
         begin
            next_st.prdata = '0;
            next_st.prdata[`SCA_MODE_PRESCALE_MSB:0] = st.prescale;
            next_st.prdata[`SCA_MODE_ALARM_IEN] = st.alarm_ien;
            next_st.prdata[`SCA_MODE_TICK_IEN] = st.tick_ien;
         end
         else if (apb.paddr == `SCA_OFF_ALARM)
         begin
            next_st.prdata = st.alarm;
         end
         else if (apb.paddr == `SCA_OFF_COUNT)
         begin
            next_st.prdata = st.count;
         end
         else if (apb.paddr == `SCA_OFF_FLAGS)
         begin
            next_st.prdata = '0;
            next_st.prdata[`SCA_FLAG_ALARM] = st.alarm_flag;
            next_st.prdata[`SCA_FLAG_TICK] = st.tick_flag;
         end
         else
         begin
            next_st.prdata = '0;
         end
      end

      if (access && apb.pwrite)
      begin
         if (apb.paddr == `SCA_OFF_MODE)
         begin
            next_st.prescale = apb.pwdata[`SCA_MODE_PRESCALE_MSB:0];
            next_st.alarm_ien = apb.pwdata[`SCA_MODE_ALARM_IEN];
            next_st.tick_ien = apb.pwdata[`SCA_MODE_TICK_IEN];
            if (apb.pwdata[`SCA_MODE_RESTART])
            begin
               next_st.rst_cnt = `SCA_SYNC_DELAY;
            end
         end
         else if (apb.paddr == `SCA_OFF_ALARM)
         begin
            next_st.alarm = apb.pwdata;
         end
      end
      if (access && !apb.pwrite && apb.paddr == `SCA_OFF_FLAGS)
      begin
         next_st.clr_cnt = `SCA_SYNC_DELAY;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st.prescale <= `SCA_RST_PRESCALE;
         st.alarm_ien <= 1'b0;
         st.tick_ien <= 1'b0;
         st.alarm <= `SCA_RST_ALARM;
         st.count <= `SCA_RST_COUNT;
         st.div <= '0;
         st.alarm_flag <= 1'b0;
         st.tick_flag <= 1'b0;
         st.sclk_q <= 1'b0;
         st.rst_cnt <= 2'h0;
         st.clr_cnt <= 2'h0;
         st.prdata <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign irq = (st.alarm_flag && st.alarm_ien) || (st.tick_flag && st.tick_ien);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_tick_sets: assert property (div_wrap |=> st.tick_flag)
      else $error("tick flag not set after divider wrap");

   a_tick_cause: assert property ($rose(st.tick_flag) |-> $past(div_wrap))
      else $error("tick flag set without a divider wrap");

   a_alarm_sets: assert property (alarm_hit |=> st.alarm_flag)
      else $error("alarm flag not set on match");

   a_alarm_cause: assert property ($rose(st.alarm_flag) |-> $past(alarm_hit))
      else $error("alarm flag set without a match");

   a_count_steps: assert property (st.count != $past(st.count) |->
      (st.count == $past(st.count) + 32'h00000001 || st.count == '0))
      else $error("counter moved by other than one or restart");

   a_count_hold: assert property (!slow_rise |=> $stable(st.count))
      else $error("counter moved without a slow clock edge");

   a_write_mode: assert property (access && apb.pwrite && apb.paddr == `SCA_OFF_MODE |=>
      st.prescale == $past(apb.pwdata[`SCA_MODE_PRESCALE_MSB:0]) &&
      st.alarm_ien == $past(apb.pwdata[`SCA_MODE_ALARM_IEN]) &&
      st.tick_ien == $past(apb.pwdata[`SCA_MODE_TICK_IEN]))
      else $error("mode write not stored");

   a_write_alarm: assert property (access && apb.pwrite && apb.paddr == `SCA_OFF_ALARM |=>
      st.alarm == $past(apb.pwdata))
      else $error("alarm write not stored");

   a_restart_arm: assert property (access && apb.pwrite && apb.paddr == `SCA_OFF_MODE &&
      apb.pwdata[`SCA_MODE_RESTART] |=> st.rst_cnt == `SCA_SYNC_DELAY)
      else $error("restart request not armed");

   a_restart_apply: assert property (slow_rise && st.rst_cnt == 2'h1 |=>
      st.count == '0 && st.div == '0)
      else $error("restart not applied on second slow edge");

   a_restart_wait: assert property (st.rst_cnt == 2'h2 && !slow_rise &&
      !(access && apb.pwrite) |=> st.rst_cnt == 2'h2)
      else $error("restart pipe advanced without slow edge");

   a_clear_arm: assert property (access && !apb.pwrite && apb.paddr == `SCA_OFF_FLAGS |=>
      st.clr_cnt == `SCA_SYNC_DELAY)
      else $error("status clear not armed");

   a_clear_wait: assert property (st.clr_cnt == 2'h2 && !slow_rise |=> st.clr_cnt == 2'h2)
      else $error("status clear advanced without slow edge");

   a_clear_apply: assert property (slow_rise && st.clr_cnt == 2'h1 && !div_wrap &&
      !alarm_hit |=> !st.tick_flag && !st.alarm_flag)
      else $error("flags not cleared on second slow edge");

   a_flag_hold: assert property (st.tick_flag && st.clr_cnt == 2'h0 |=> st.tick_flag)
      else $error("tick flag dropped without a status read");

   a_alarm_hold: assert property (st.alarm_flag && st.clr_cnt == 2'h0 |=> st.alarm_flag)
      else $error("alarm flag dropped without a status read");

   a_read_mode: assert property (setup && !apb.pwrite && apb.paddr == `SCA_OFF_MODE |=>
      prdata[`SCA_MODE_PRESCALE_MSB:0] == $past(st.prescale) && !prdata[`SCA_MODE_RESTART])
      else $error("mode read returned wrong value");

   a_read_alarm: assert property (setup && !apb.pwrite && apb.paddr == `SCA_OFF_ALARM |=>
      prdata == $past(st.alarm))
      else $error("alarm read returned wrong value");

   a_read_count: assert property (setup && !apb.pwrite && apb.paddr == `SCA_OFF_COUNT |=>
      prdata == $past(st.count))
      else $error("count read returned wrong value");

   a_read_flags: assert property (setup && !apb.pwrite && apb.paddr == `SCA_OFF_FLAGS |=>
      prdata[31:2] == '0 && prdata[`SCA_FLAG_TICK] == $past(st.tick_flag) &&
      prdata[`SCA_FLAG_ALARM] == $past(st.alarm_flag))
      else $error("status read returned wrong value");

   // Read data stands from its setup cycle until the next read setup.
   a_rdata_hold: assert property (!(setup && !apb.pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read setup");

   a_slverr_set: assert property (access && apb.paddr > `SCA_OFF_FLAGS |-> pslverr)
      else $error("no error for an address above the register map");

   a_slverr_clear: assert property (access && apb.paddr == `SCA_OFF_COUNT |-> !pslverr)
      else $error("error raised for a mapped register");

   a_irq_gated: assert property (!st.alarm_ien && !st.tick_ien |-> !irq)
      else $error("interrupt raised while disabled");

   a_irq_alarm: assert property (st.alarm_flag && st.alarm_ien |-> irq)
      else $error("enabled alarm flag did not raise the interrupt");

   a_irq_tick: assert property (st.tick_flag && st.tick_ien |-> irq)
      else $error("enabled tick flag did not raise the interrupt");

   a_irq_none: assert property (!st.alarm_flag && !st.tick_flag |-> !irq)
      else $error("interrupt raised with no flag set");

   // Covers mark the main scenarios as reached.
   c_tick: cover property (div_wrap ##1 st.tick_flag);
   c_tick_irq: cover property (st.tick_flag && st.tick_ien && irq);
   c_alarm_irq: cover property (st.alarm_flag && st.alarm_ien && irq);
   c_restart: cover property (st.rst_cnt == 2'h1 && slow_rise ##1 st.count == '0);
   c_clear: cover property (st.clr_cnt == 2'h1 && slow_rise);

endmodule : sca_timer

// ===== logic/sca_defines.svh
`ifndef SCA_DEFINES_SVH
`define SCA_DEFINES_SVH

// Bus geometry.
`define SCA_AW 12
`define SCA_DW 32
`define SCA_PW 16

// Register byte offsets.
`define SCA_OFF_MODE 12'h000
`define SCA_OFF_ALARM 12'h004
`define SCA_OFF_COUNT 12'h008
`define SCA_OFF_FLAGS 12'h00c

// Mode register fields.
`define SCA_MODE_PRESCALE_MSB 15
`define SCA_MODE_ALARM_IEN 16
`define SCA_MODE_TICK_IEN 17
`define SCA_MODE_RESTART 18

// Status register fields.
`define SCA_FLAG_ALARM 0
`define SCA_FLAG_TICK 1

// Reset values.
`define SCA_RST_PRESCALE 16'h8000
`define SCA_RST_ALARM 32'hffffffff
`define SCA_RST_COUNT 32'h00000000

// Divider period used when the prescale field is zero.
`define SCA_PERIOD_MAX 17'h10000

// Slow clock rising edges between a request and its effect.
`define SCA_SYNC_DELAY 2'h2

`endif

// ===== logic/sca_pkg.sv
`include "sca_defines.svh"

package sca_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`SCA_AW-1:0] paddr;
      logic [`SCA_DW-1:0] pwdata;
   } sca_apb_req_t;

   typedef struct packed {
      logic [`SCA_PW-1:0] prescale;
      logic alarm_ien;
      logic tick_ien;
      logic [`SCA_DW-1:0] alarm;
      logic [`SCA_DW-1:0] count;
      logic [`SCA_PW-1:0] div;
      logic alarm_flag;
      logic tick_flag;
      logic sclk_q;
      logic [1:0] rst_cnt;
      logic [1:0] clr_cnt;
      logic [`SCA_DW-1:0] prdata;
   } sca_state_t;

endpackage : sca_pkg

// ===== verif/sca_timer_test.sv
`timescale 1ns/1ps
`include "sca_defines.svh"

module sca_timer_test;
   import sca_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic slow_clock = 1'b0;
   sca_apb_req_t apb = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rdata;
   logic err;
   int mismatches = 0;
   int checks = 0;

   sca_timer sca_timer_inst (
      .pclk(pclk),
      .presetn(presetn),
      .apb(apb),
      .slow_clock(slow_clock),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq)
   );

   always #25 pclk = ~pclk;

   task automatic print_verdict;
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; an idle cycle follows so the next setup never collides with the release.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb.penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   // Each pulse is one slow clock period as seen by pclk.
   task automatic slow_edges(input int n);
      repeat (n)
      begin
         slow_clock <= 1'b1;
         repeat (2) @(posedge pclk);
         slow_clock <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask : slow_edges

   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd(`SCA_OFF_MODE, 32'h00008000);
      rd(`SCA_OFF_ALARM, 32'hffffffff);
      rd(`SCA_OFF_COUNT, 32'h0);
      rd(`SCA_OFF_FLAGS, 32'h0);
      rd(12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(`SCA_OFF_MODE, 32'h00060003);
      rd(`SCA_OFF_MODE, 32'h00020003);
      slow_edges(2);
      rd(`SCA_OFF_COUNT, 32'h0);
      slow_edges(2);
      rd(`SCA_OFF_COUNT, 32'h0);
      slow_edges(1);
      rd(`SCA_OFF_COUNT, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(`SCA_OFF_FLAGS, 32'h2);
      slow_edges(1);
      chk({31'h0, irq}, 32'h1);
      slow_edges(1);
      chk({31'h0, irq}, 32'h0);
      wr(`SCA_OFF_ALARM, 32'h1);
      wr(`SCA_OFF_MODE, 32'h00010003);
      chk({31'h0, irq}, 32'h0);
      slow_edges(1);
      chk({31'h0, irq}, 32'h1);
      rd(`SCA_OFF_FLAGS, 32'h3);
      wr(`SCA_OFF_COUNT, 32'h55);
      rd(`SCA_OFF_COUNT, 32'h2);
      wr(`SCA_OFF_MODE, 32'h00060003);
      slow_edges(1);
      rd(`SCA_OFF_COUNT, 32'h2);
      slow_edges(1);
      rd(`SCA_OFF_COUNT, 32'h0);
      print_verdict();
   end

   // The tests need about a hundred cycles; this span of 2000 cycles is far beyond that.
   initial
   begin
      #100000;
      mismatches++;
      print_verdict();
   end
endmodule : sca_timer_test
